// ### hw/clock_sync_pkg.sv
// Constants, types and helpers shared by the output clock and sync block
package clock_sync_pkg;

	// Register byte offsets on the Avalon-MM slave
	localparam logic [4:0]  SYNTH_CTRL_OFS = 5'h00;
	localparam logic [4:0]  FREQ_SEL_OFS   = 5'h04;
	localparam logic [4:0]  SHAPE_OFS      = 5'h08;
	localparam logic [4:0]  OUT_EN_OFS     = 5'h0C;
	localparam logic [4:0]  STATUS_OFS     = 5'h10;

	// Field positions
	localparam int          RATE_A_SONET_BIT = 0;
	localparam int          RATE_B_SONET_BIT = 1;
	localparam int          DFS_SRC_BIT      = 2;
	localparam int          RATE_A_LSB       = 4;
	localparam int          RATE_B_LSB       = 6;
	localparam int          GEN_AUX_BIT      = 7;
	localparam int          SHAPE8_LSB       = 2;
	localparam int          SHAPE2_LSB       = 0;
	localparam int          FS_DIS_BIT       = 7;
	localparam int          MFS_DIS_BIT      = 6;

	// Reset values
	localparam logic [7:0]  SYNTH_CTRL_RST = 8'h00;
	localparam logic [15:0] FREQ_SEL_RST   = 16'h0000;
	localparam logic [7:0]  SHAPE_RST      = 8'h00;
	localparam logic [7:0]  OUT_EN_RST     = 8'h00;

	// General output rate field codes
	localparam logic [3:0]  FREQ_OFF    = 4'h0;
	localparam logic [3:0]  FREQ_2K     = 4'h1;
	localparam logic [3:0]  FREQ_8K     = 4'h2;
	localparam logic [3:0]  FREQ_RATE_B = 4'h3;
	localparam logic [3:0]  FREQ_RATE_A = 4'h4;

	// Timing
	localparam int          CLK_HZ      = 20_000_000;
	localparam int          HOLD_MS     = 250;
	localparam int          HOLD_CYCLES = CLK_HZ / 1000 * HOLD_MS;

	// Phase increments: rate / 77.76 MHz * 2^32
	localparam int          ACC_W     = 32;
	localparam logic [31:0] INC_2048  = 32'h06BE_0D10;
	localparam logic [31:0] INC_4096  = 32'h0D7C_1A20;
	localparam logic [31:0] INC_8192  = 32'h1AF8_3440;
	localparam logic [31:0] INC_16384 = 32'h35F0_6881;
	localparam logic [31:0] INC_1544  = 32'h0515_47D9;
	localparam logic [31:0] INC_3088  = 32'h0A2A_8FB2;
	localparam logic [31:0] INC_6176  = 32'h1455_1F64;
	localparam logic [31:0] INC_12352 = 32'h28AA_3EC9;

	typedef struct packed {
		logic edge8;
		logic edge2;
	} path_edges_t;

	typedef enum {RUN_HOLD, RUN_ACTIVE} run_state_t;

	function automatic logic [31:0] rate_inc(input logic [1:0] code,
	                                         input logic       sonet);
		logic [31:0] r;
		r = INC_2048;
		case ({sonet, code})
			3'b000:  r = INC_2048;
			3'b001:  r = INC_4096;
			3'b010:  r = INC_8192;
			3'b011:  r = INC_16384;
			3'b100:  r = INC_1544;
			3'b101:  r = INC_3088;
			3'b110:  r = INC_6176;
			default: r = INC_12352;
		endcase
		return r;
	endfunction : rate_inc

endpackage : clock_sync_pkg

// ### hw/output_clock_sync_select.sv
// Output clock synthesis, frame sync shaping and general output selection
// Notes on behaviour
// - Rate A picks 2.048..16.384 or 1.544..12.352 MHz by code and SONET bit.
// - Rate B uses its own code and SONET bit with the same mapping.
// - Both rates come from one synthesiser fed by main or APLL 77.76 MHz.
// - Synthesised rates skip jitter filtering; edges land on synth ticks.
// - Frame and multiframe sync always come from the main timing path.
// - General 2 kHz and 8 kHz options share one main/aux source bit.
// - Each such output is a 50:50 clock or a pulse, optionally inverted.
// - A pulse lasts exactly one period of general output three's clock.
// - 8 kHz/frame and 2 kHz/multiframe shaping share one register.
// - Frame and multiframe sync each have a disable in bits 7 and 6.
// - Reset low acts asynchronously and restores all register defaults.
// - After reset release the block stays held for 250 ms.
// - Rate field 0001 gives 2 kHz, 0010 gives 8 kHz, 0000 turns off.
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ns
module output_clock_sync_select
	import clock_sync_pkg::*;
#(
	parameter int HOLD_COUNT = HOLD_CYCLES
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// Avalon-MM slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Timing path edge strobes and clock of general output three
	input  wire path_edges_t main_timing_path,
	input  wire path_edges_t aux_timing_path,
	input  wire logic        general_output_three,
	// 77.76 MHz synthesiser ticks
	input  wire logic        synth_tick_main,
	input  wire logic        synth_tick_apll,
	// Outputs
	output logic             frame_sync_out,
	output logic             multiframe_sync_out,
	output logic      [3:0]  gen_out,
	output logic             synth_rate_a,
	output logic             synth_rate_b,
	output logic             running
);

	logic [7:0]  synth_ctrl_q;
	logic [15:0] freq_sel_q;
	logic [7:0]  shape_q;
	logic [7:0]  out_en_q;
	logic        wait_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	run_state_t  state_q;
	logic [22:0] hold_cnt_q;
	logic        hold;
	logic        run_q;
	logic [31:0] inc_a_q;
	logic [31:0] inc_b_q;
	logic        dfs_step_q;
	logic [3:0]  ev;
	logic [3:0]  sq_q;
	logic [3:0]  pend_q;
	logic [3:0]  act_q;
	logic        fs_q;
	logic        mfs_q;
	logic [3:0]  gen_q;
	logic        o3_prev_q;
	logic        o3_rise;
	logic        bus_wr;

	localparam logic [22:0] HOLD_LAST = 23'(HOLD_COUNT - 1);

	assign hold    = (state_q == RUN_HOLD);
	assign bus_wr  = avs_write && !wait_q && !hold;
	assign o3_rise = general_output_three && !o3_prev_q;
	assign ev      = {aux_timing_path.edge2, aux_timing_path.edge8,
	                  main_timing_path.edge2, main_timing_path.edge8};

	function automatic logic shape(input logic sq, input logic act,
	                               input logic pulse, input logic inv);
		return (pulse ? act : sq) ^ inv;
	endfunction : shape

	// Power-on hold-off after reset release
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q    <= RUN_HOLD;
			hold_cnt_q <= '0;
			run_q      <= 1'b0;
		end else begin
			case (state_q)
				RUN_HOLD: begin
					if (hold_cnt_q == HOLD_LAST) begin
						state_q <= RUN_ACTIVE;
						run_q   <= 1'b1;
					end else begin
						hold_cnt_q <= hold_cnt_q + 23'h000001;
					end
				end
				RUN_ACTIVE: state_q <= RUN_ACTIVE;
				default: begin
					state_q <= RUN_HOLD;
					run_q   <= 1'b0;
				end
			endcase
		end
	end

	// Avalon wait state: every access answers on its second cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			wait_q <= !((avs_read || avs_write) && wait_q);
			if (avs_read && wait_q) begin
				rdata_q <= rdata_d;
			end
		end
	end

	always_comb begin
		rdata_d = 32'h0000_0000;
		case (avs_address)
			SYNTH_CTRL_OFS: rdata_d[7:0]  = synth_ctrl_q;
			FREQ_SEL_OFS:   rdata_d[15:0] = freq_sel_q;
			SHAPE_OFS:      rdata_d[7:0]  = shape_q;
			OUT_EN_OFS:     rdata_d[7:0]  = out_en_q;
			STATUS_OFS:     rdata_d[3:0]  = {synth_rate_b, synth_rate_a,
			                                 mfs_q, !hold};
			default:        rdata_d = 32'h0000_0000;
		endcase
	end

	// Configuration registers; writes ignored during hold-off
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			synth_ctrl_q <= SYNTH_CTRL_RST;
			freq_sel_q   <= FREQ_SEL_RST;
			shape_q      <= SHAPE_RST;
			out_en_q     <= OUT_EN_RST;
		end else if (bus_wr) begin
			case (avs_address)
				SYNTH_CTRL_OFS: synth_ctrl_q <= avs_writedata[7:0];
				FREQ_SEL_OFS:   freq_sel_q   <= avs_writedata[15:0];
				SHAPE_OFS:      shape_q      <= avs_writedata[7:0];
				OUT_EN_OFS:     out_en_q     <= avs_writedata[7:0];
				default:        out_en_q     <= out_en_q;
			endcase
		end
	end

	// Synthesiser step source and rate increments
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dfs_step_q <= 1'b0;
			inc_a_q    <= INC_2048;
			inc_b_q    <= INC_2048;
		end else begin
			dfs_step_q <= synth_ctrl_q[DFS_SRC_BIT] ? synth_tick_apll
			                                        : synth_tick_main;
			inc_a_q <= rate_inc(synth_ctrl_q[RATE_A_LSB +: 2],
			                    synth_ctrl_q[RATE_A_SONET_BIT]);
			inc_b_q <= rate_inc(synth_ctrl_q[RATE_B_LSB +: 2],
			                    synth_ctrl_q[RATE_B_SONET_BIT]);
		end
	end

	// Unfiltered rates, edges aligned to synthesiser ticks
	phase_accum #(.ACC_W(ACC_W)) rate_a_acc (
		.clk   (clk),
		.nrst  (nrst),
		.clear (hold),
		.step  (dfs_step_q),
		.inc   (inc_a_q),
		.out_q (synth_rate_a)
	);

	phase_accum #(.ACC_W(ACC_W)) rate_b_acc (
		.clk   (clk),
		.nrst  (nrst),
		.clear (hold),
		.step  (dfs_step_q),
		.inc   (inc_b_q),
		.out_q (synth_rate_b)
	);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			o3_prev_q <= 1'b0;
		end else begin
			o3_prev_q <= general_output_three;
		end
	end

	// Shapers: 0 main 8k, 1 main 2k, 2 aux 8k, 3 aux 2k
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sq_q   <= 4'h0;
			pend_q <= 4'h0;
			act_q  <= 4'h0;
		end else if (hold) begin
			sq_q   <= 4'h0;
			pend_q <= 4'h0;
			act_q  <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (ev[i]) begin
					sq_q[i] <= !sq_q[i];
				end
				if (ev[i] && !sq_q[i]) begin
					pend_q[i] <= 1'b1;
				end else if (o3_rise) begin
					pend_q[i] <= 1'b0;
				end
				if (o3_rise) begin
					act_q[i] <= pend_q[i];
				end
			end
		end
	end

	// Sync outputs from the main path only
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fs_q  <= 1'b0;
			mfs_q <= 1'b0;
		end else begin
			fs_q <= !hold && !out_en_q[FS_DIS_BIT] &&
			        shape(sq_q[0], act_q[0], shape_q[SHAPE8_LSB+1],
			              shape_q[SHAPE8_LSB]);
			mfs_q <= !hold && !out_en_q[MFS_DIS_BIT] &&
			         shape(sq_q[1], act_q[1], shape_q[SHAPE2_LSB+1],
			               shape_q[SHAPE2_LSB]);
		end
	end

	// General outputs; 2k/8k share one path select
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gen_q <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				case (freq_sel_q[4*i +: 4])
					FREQ_OFF: gen_q[i] <= 1'b0;
					FREQ_2K: gen_q[i] <= shape(
					    shape_q[GEN_AUX_BIT] ? sq_q[3] : sq_q[1],
					    shape_q[GEN_AUX_BIT] ? act_q[3] : act_q[1],
					    shape_q[SHAPE2_LSB+1], shape_q[SHAPE2_LSB]);
					FREQ_8K: gen_q[i] <= shape(
					    shape_q[GEN_AUX_BIT] ? sq_q[2] : sq_q[0],
					    shape_q[GEN_AUX_BIT] ? act_q[2] : act_q[0],
					    shape_q[SHAPE8_LSB+1], shape_q[SHAPE8_LSB]);
					FREQ_RATE_B: gen_q[i] <= (i != 0) && synth_rate_b;
					FREQ_RATE_A: gen_q[i] <= synth_rate_a;
					default: gen_q[i] <= 1'b0;
				endcase
				if (hold) begin
					gen_q[i] <= 1'b0;
				end
			end
		end
	end

	assign avs_waitrequest     = wait_q;
	assign avs_readdata        = rdata_q;
	assign frame_sync_out      = fs_q;
	assign multiframe_sync_out = mfs_q;
	assign gen_out             = gen_q;
	assign running             = run_q;

	wait_answer_a: assert property (@(posedge clk) disable iff (!nrst)
		(avs_read || avs_write) && wait_q |=> !wait_q)
		else $error("access not answered on second cycle");

	hold_length_a: assert property (@(posedge clk) disable iff (!nrst)
		$rose(running) |-> $past(hold_cnt_q) == HOLD_LAST)
		else $error("hold-off ended at wrong count");

	hold_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
		hold |=> !frame_sync_out && !multiframe_sync_out && gen_out == 4'h0)
		else $error("outputs active during hold-off");

	rate_a_code_a: assert property (@(posedge clk) disable iff (!nrst)
		synth_ctrl_q[RATE_A_LSB +: 2] == 2'b10 &&
		synth_ctrl_q[RATE_A_SONET_BIT] |=> inc_a_q == INC_6176)
		else $error("rate A increment wrong");

	rate_b_code_a: assert property (@(posedge clk) disable iff (!nrst)
		synth_ctrl_q[RATE_B_LSB +: 2] == 2'b11 &&
		!synth_ctrl_q[RATE_B_SONET_BIT] |=> inc_b_q == INC_16384)
		else $error("rate B increment wrong");

	fs_disable_a: assert property (@(posedge clk) disable iff (!nrst)
		out_en_q[FS_DIS_BIT] |=> !frame_sync_out)
		else $error("frame sync not disabled");

	fs_main_inv_a: assert property (@(posedge clk) disable iff (!nrst)
		!hold && !out_en_q[FS_DIS_BIT] && !shape_q[SHAPE8_LSB+1] &&
		shape_q[SHAPE8_LSB] |=> frame_sync_out == !$past(sq_q[0]))
		else $error("frame sync clock not inverted main path");

	mfs_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
		!hold && !out_en_q[MFS_DIS_BIT] && shape_q[SHAPE2_LSB+1] &&
		!shape_q[SHAPE2_LSB] |=> multiframe_sync_out == $past(act_q[1]))
		else $error("multiframe pulse mismatch");

	pulse_width_a: assert property (@(posedge clk) disable iff (!nrst)
		!hold && o3_rise && !pend_q[0] |=> !act_q[0])
		else $error("pulse longer than one o3 period");

	pulse_hold_a: assert property (@(posedge clk) disable iff (!nrst)
		!hold && !o3_rise |=> act_q[0] == $past(act_q[0]))
		else $error("pulse changed between o3 edges");

	gen_aux_a: assert property (@(posedge clk) disable iff (!nrst)
		!hold && freq_sel_q[3:0] == FREQ_8K && shape_q[GEN_AUX_BIT] &&
		shape_q[SHAPE8_LSB +: 2] == 2'b00 |=> gen_out[0] == $past(sq_q[2]))
		else $error("general 8k not from aux path");

	gen_off_a: assert property (@(posedge clk) disable iff (!nrst)
		freq_sel_q[7:4] == FREQ_OFF |=> !gen_out[1])
		else $error("general output not off");

	mfs_disable_a: assert property (@(posedge clk) disable iff (!nrst)
		out_en_q[MFS_DIS_BIT] |=> !multiframe_sync_out)
		else $error("multiframe sync not disabled");

	dfs_source_a: assert property (@(posedge clk) disable iff (!nrst)
		synth_ctrl_q[DFS_SRC_BIT] |=>
		dfs_step_q == $past(synth_tick_apll))
		else $error("synthesiser step not from selected tick");

	fs_main_path_a: assert property (@(posedge clk) disable iff (!nrst)
		!hold && main_timing_path.edge8 |=> sq_q[0] != $past(sq_q[0]))
		else $error("frame square not toggled by main path");

	mfs_main_path_a: assert property (@(posedge clk) disable iff (!nrst)
		!hold && main_timing_path.edge2 |=> sq_q[1] != $past(sq_q[1]))
		else $error("multiframe square not toggled by main path");

	pulse_arm_a: assert property (@(posedge clk) disable iff (!nrst)
		!hold && main_timing_path.edge8 && !sq_q[0] |=> pend_q[0])
		else $error("pulse not armed on square rise");

	wait_idle_a: assert property (@(posedge clk) disable iff (!nrst)
		!(avs_read || avs_write) |=> avs_waitrequest)
		else $error("waitrequest low without a request");

	gen_synth_a: assert property (@(posedge clk) disable iff (!nrst)
		!hold && freq_sel_q[15:12] == FREQ_RATE_A |=>
		gen_out[3] == $past(synth_rate_a))
		else $error("general output not carrying rate A");

endmodule : output_clock_sync_select

// ### hw/phase_accum.sv
// Phase accumulator that forms one synthesised square rate
`timescale 1ns/1ns
module phase_accum #(
	parameter int ACC_W = 32
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	// Control
	input  wire logic             clear,
	input  wire logic             step,
	input  wire logic [ACC_W-1:0] inc,
	// Output
	output logic                  out_q
);

	logic [ACC_W-1:0] acc_q;

	// The MSB toggles once per accumulator overflow half-cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			acc_q <= '0;
		end else if (clear) begin
			acc_q <= '0;
		end else if (step) begin
			acc_q <= acc_q + inc;
		end
	end

	assign out_q = acc_q[ACC_W-1];

endmodule : phase_accum

// ### sim/output_clock_sync_select_test.sv
// Self-checking bench for the output clock and sync block
`timescale 1ns/1ns
module output_clock_sync_select_test;
	import clock_sync_pkg::*;

	localparam int HOLD = 20;
	localparam int RK [8] = '{2048, 4096, 8192, 16384,
	                          1544, 3088, 6176, 12352};
	localparam logic [7:0] SHP [5] = '{8'h04, 8'h08, 8'h0E, 8'h03, 8'h80};
	// fs high, fs low, mfs high, mfs low, 8k high, 2k high (-1 = skip)
	localparam int EX [5][6] = '{'{10, 10, 40, 40, 10, 40},
	                             '{2, 18, 40, 40, -1, -1},
	                             '{18, 2, 2, 78, -1, -1},
	                             '{10, 10, 78, 2, -1, -1},
	                             '{10, 10, 40, 40, 14, 56}};

	logic        clk, nrst, avs_read, avs_write, avs_waitrequest;
	logic [4:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	path_edges_t main_timing_path, aux_timing_path;
	logic        general_output_three, synth_tick_main, synth_tick_apll;
	logic        frame_sync_out, multiframe_sync_out, synth_rate_a;
	logic        synth_rate_b, running, clr;
	logic [3:0]  gen_out;
	logic [7:0]  lines;
	int          cyc, since_rel, error_cnt, samples_checked, i;
	int          rises [8];
	int          hi [8];
	int          lo [8];

	output_clock_sync_select #(.HOLD_COUNT(HOLD))
	output_clock_sync_select_inst (
		.clk(clk), .nrst(nrst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.main_timing_path(main_timing_path),
		.aux_timing_path(aux_timing_path),
		.general_output_three(general_output_three),
		.synth_tick_main(synth_tick_main), .synth_tick_apll(synth_tick_apll),
		.frame_sync_out(frame_sync_out),
		.multiframe_sync_out(multiframe_sync_out), .gen_out(gen_out),
		.synth_rate_a(synth_rate_a), .synth_rate_b(synth_rate_b),
		.running(running));

	assign lines = {gen_out[3], synth_rate_b, synth_rate_a, gen_out[2:0],
	                multiframe_sync_out, frame_sync_out};
	for (genvar g = 0; g < 8; g++) begin : g_sink
		sync_sink sync_sink_inst (.clk(clk), .nrst(nrst), .line(lines[g]),
			.clr(clr), .rises_q(rises[g]), .hi_q(hi[g]), .lo_q(lo[g]));
	end

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Path strobes, fast third output clock and synthesiser ticks
	always @(posedge clk) begin
		cyc                  <= cyc + 1;
		main_timing_path     <= '{cyc % 10 == 0, cyc % 40 == 0};
		aux_timing_path      <= '{cyc % 14 == 0, cyc % 56 == 0};
		general_output_three <= ~general_output_three;
		synth_tick_main      <= 1'b1;
		synth_tick_apll      <= cyc[0];
		since_rel            <= nrst ? since_rel + 1 : 0;
	end

	task automatic end_of_test();
		if (error_cnt == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test

	task automatic check(input string n, input logic [31:0] e,
	                     input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask : check

	task automatic check_near(input string n, input int e, input int g,
	                          input int tol);
		if (e >= 0) begin
			samples_checked++;
			if (g < e - tol || g > e + tol) begin
				error_cnt++;
				$display("unexpected %s: expected %0d, seen %0d", n, e, g);
			end
		end
	endtask : check_near

	// One Avalon access, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [4:0] a,
	                   input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= w;
		avs_read      <= !w;
		do
			@(posedge clk);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask : bus

	task automatic reg_rd(input string n, input logic [4:0] a,
	                      input logic [31:0] e);
		bus(1'b0, a, 32'h0, rd);
		check(n, e, rd);
	endtask : reg_rd

	task automatic measure(input int n);
		repeat (250) @(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		repeat (n) @(posedge clk);
	endtask : measure

	task automatic wait_running();
		for (int k = 0; k < 200 && running !== 1'b1; k++)
			@(posedge clk);
		check_near("hold", HOLD, since_rel, 2);
	endtask : wait_running

	initial begin
		repeat (40000) @(posedge clk);
		error_cnt++;
		end_of_test();
	end

	initial begin
		{nrst, avs_read, avs_write, avs_address, avs_writedata, clr} = '0;
		{main_timing_path, aux_timing_path, general_output_three} = '0;
		{synth_tick_main, synth_tick_apll, cyc, since_rel} = '0;
		{error_cnt, samples_checked} = '0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		wait_running();
		reg_rd("unmapped", 5'h14, 32'h0);
		bus(1'b0, STATUS_OFS, 32'h0, rd);
		check("running bit", 32'h1, {31'h0, rd[0]});
		bus(1'b1, FREQ_SEL_OFS, 32'h0012, rd);
		reg_rd("freq sel", FREQ_SEL_OFS, 32'h0012);
		for (i = 0; i < 8; i++) begin
			bus(1'b1, SYNTH_CTRL_OFS, 32'(((7 - i) % 4) * 64 + (i % 4) * 16
				+ ((7 - i) / 4) * 2 + i / 4), rd);
			measure(2000);
			check_near("rate a", 2000 * RK[i] / 77760, rises[5], 1);
			check_near("rate b", 2000 * RK[7 - i] / 77760, rises[6], 1);
		end
		bus(1'b1, SYNTH_CTRL_OFS, 32'h04, rd);
		measure(2000);
		check_near("alt tick rate", 1000 * RK[0] / 77760, rises[5], 1);
		for (i = 0; i < 5; i++) begin
			bus(1'b1, SHAPE_OFS, {24'h0, SHP[i]}, rd);
			measure(10);
			check_near("fs high", EX[i][0], hi[0], 0);
			check_near("fs low", EX[i][1], lo[0], 0);
			check_near("mfs high", EX[i][2], hi[1], 0);
			check_near("mfs low", EX[i][3], lo[1], 0);
			check_near("gen 8k", EX[i][4], hi[2], 0);
			check_near("gen 2k", EX[i][5], hi[3], 0);
			check_near("gen off", 0, rises[4], 0);
		end
		bus(1'b1, SYNTH_CTRL_OFS, 32'hC4, rd);
		bus(1'b1, FREQ_SEL_OFS, 32'h4312, rd);
		measure(2000);
		check_near("gen rate b", 1000 * RK[3] / 77760, rises[4], 1);
		check_near("gen rate a", 1000 * RK[0] / 77760, rises[7], 1);
		bus(1'b1, OUT_EN_OFS, 32'h80, rd);
		measure(400);
		check_near("fs disabled", 0, rises[0], 0);
		check_near("mfs enabled", 5, rises[1], 1);
		bus(1'b1, OUT_EN_OFS, 32'hC0, rd);
		measure(400);
		check_near("mfs disabled", 0, rises[1], 0);
		@(posedge clk);
		nrst <= 1'b0;
		repeat (10) @(posedge clk);
		check("outputs in reset", 32'h0, 32'({running, gen_out, frame_sync_out,
			multiframe_sync_out, synth_rate_a, synth_rate_b}));
		nrst <= 1'b1;
		bus(1'b1, SHAPE_OFS, 32'hFF, rd);
		wait_running();
		reg_rd("shape", SHAPE_OFS, {24'h0, SHAPE_RST});
		reg_rd("synth ctrl", SYNTH_CTRL_OFS, {24'h0, SYNTH_CTRL_RST});
		reg_rd("freq sel rst", FREQ_SEL_OFS, {16'h0, FREQ_SEL_RST});
		reg_rd("out en", OUT_EN_OFS, {24'h0, OUT_EN_RST});
		end_of_test();
	end
endmodule : output_clock_sync_select_test

// ### sim/sync_sink.sv
// Downstream sink that measures run lengths and rising edges of one line
`timescale 1ns/1ns
module sync_sink (
	// Clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// Observed line and count clear
	input  wire logic line,
	input  wire logic clr,
	// Measurements in clock cycles
	output int        rises_q,
	output int        hi_q,
	output int        lo_q
);
	logic prev_q;
	int   run_q;

	// Keeps the last completed high and low runs
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prev_q <= 1'b0;
			run_q  <= 0;
			hi_q   <= 0;
			lo_q   <= 0;
		end else begin
			prev_q <= line;
			run_q  <= (line !== prev_q) ? 1 : run_q + 1;
			if (line !== prev_q && prev_q === 1'b1)
				hi_q <= run_q;
			if (line !== prev_q && prev_q === 1'b0)
				lo_q <= run_q;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			rises_q <= 0;
		else if (clr)
			rises_q <= 0;
		else if (line === 1'b1 && prev_q === 1'b0)
			rises_q <= rises_q + 1;
	end
endmodule : sync_sink
